// ==== src/ptu_pkg.sv ====
package ptu_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int TICK_W    = 20;
  localparam int ELAPSED_W = 12;
  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 8;
  localparam int EVT_W     = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int DIV_RATIO = 16;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_TIMER_MODE     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TIMER_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_VALUE_ACK      = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_VALUE_PEEK     = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MASK     = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_LIMIT_LSB     = 0;
  localparam int MODE_TIMER_EN_BIT  = 24;
  localparam int MODE_IRQ_EN_BIT    = 25;
  localparam int STATUS_FLAG_BIT    = 0;
  localparam int VALUE_TICK_LSB     = 0;
  localparam int VALUE_ELAPSED_LSB  = 20;
  localparam int EVT_WRAP_BIT       = 0;
  localparam int EVT_ROLL_BIT       = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [TICK_W-1:0]    LIMIT_RST     = 20'hfffff;
  localparam logic                 TIMER_EN_RST  = 1'b0;
  localparam logic                 IRQ_EN_RST    = 1'b0;
  localparam logic [EVT_W-1:0]     EVT_MASK_RST  = 2'h0;

endpackage

// ==== src/ptu_prescaler.sv ====
`timescale 1ns/1ps

// Divides core_clk into a one-cycle enable pulse every DIV cycles.
module ptu_prescaler #(
  parameter int DIV = ptu_pkg::DIV_RATIO
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic halt,
  output logic      tickEn
);
  import ptu_pkg::*;

  localparam int CNT_W = $clog2(DIV);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             pulse;
  } ptu_presc_type;

  ptu_presc_type cur_r;
  ptu_presc_type cur_nxt;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_comb begin
    cur_nxt       = cur_r;
    cur_nxt.pulse = 1'b0;
    // Frozen in debug so no new pulse is made while halted
    if (!halt) begin
      if (cur_r.cnt == CNT_W'(DIV - 1)) begin
        cur_nxt.cnt   = '0;
        cur_nxt.pulse = 1'b1;
      end else begin
        cur_nxt.cnt = cur_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_r <= '0;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign tickEn = cur_r.pulse;

endmodule

// ==== src/ptu_timer.sv ====
// Local design decision: strobed register access.
`timescale 1ns/1ps

// Operation
// - 20/12-bit counters advance on clock/16 enables
// - Tick counts from zero, wraps, bumps elapsed
// - Wrap sets flag; irq when flag and enabled
// - New limit write keeps both counters running
// - Value-ack read returns counters, clears count, flag
// - Peek read returns counters, changes nothing
// - Enable resets low, applies when tick is zero
// - Disabled timer finishes interval, then idles at zero
// - Debug state freezes both counters
// - Period is limit plus one divided ticks
// - Elapsed counts intervals since last ack read
// - Flag reads one if wrapped since ack read
module ptu_timer (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          coreDebugHalt,
  input  wire logic [ptu_pkg::ADDR_W-1:0]    regAddr,
  input  wire logic [ptu_pkg::DATA_W-1:0]    regWrData,
  input  wire logic                          regWrStb,
  input  wire logic                          regRdStb,
  output logic      [ptu_pkg::DATA_W-1:0]    regRdData,
  output logic                               irq
);
  import ptu_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [TICK_W-1:0]    tick;
    logic [ELAPSED_W-1:0] elapsed;
    logic                 reachedFlag;
    logic [TICK_W-1:0]    limit;
    logic                 timerEn;
    logic                 irqEn;
    logic                 running;
    logic [EVT_W-1:0]     evtStatus;
    logic [EVT_W-1:0]     evtMask;
    logic [DATA_W-1:0]    rdData;
    logic                 irqOut;
  } ptu_state_type;

  localparam ptu_state_type STATE_RST = '{
    tick:        '0,
    elapsed:     '0,
    reachedFlag: 1'b0,
    limit:       LIMIT_RST,
    timerEn:     TIMER_EN_RST,
    irqEn:       IRQ_EN_RST,
    running:     1'b0,
    evtStatus:   '0,
    evtMask:     EVT_MASK_RST,
    rdData:      '0,
    irqOut:      1'b0
  };

  ptu_state_type st_r;
  ptu_state_type st_nxt;

  logic divTick;

  // ----------------------------------------------------------------
  // Divided clock enable
  // ----------------------------------------------------------------
  ptu_prescaler #(
    .DIV (DIV_RATIO)
  ) u_prescaler (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .halt     (coreDebugHalt),
    .tickEn   (divTick)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wrMode;
  logic wrEvtStatus;
  logic wrEvtMask;
  logic rdAck;

  always_comb begin
    wrMode      = 1'b0;
    wrEvtStatus = 1'b0;
    wrEvtMask   = 1'b0;
    if (regWrStb) begin
      if (regAddr == OFS_TIMER_MODE) begin
        wrMode = 1'b1;
      end else if (regAddr == OFS_EVENT_STATUS) begin
        wrEvtStatus = 1'b1;
      end else if (regAddr == OFS_EVENT_MASK) begin
        wrEvtMask = 1'b1;
      end
    end
  end

  assign rdAck = regRdStb && (regAddr == OFS_VALUE_ACK);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rdWord;
  logic [DATA_W-1:0] valueWord;

  always_comb begin
    valueWord = '0;
    valueWord[VALUE_TICK_LSB +: TICK_W]       = st_r.tick;
    valueWord[VALUE_ELAPSED_LSB +: ELAPSED_W] = st_r.elapsed;
  end

  always_comb begin
    rdWord = '0;
    if (regAddr == OFS_TIMER_MODE) begin
      rdWord[MODE_LIMIT_LSB +: TICK_W] = st_r.limit;
      rdWord[MODE_TIMER_EN_BIT]        = st_r.timerEn;
      rdWord[MODE_IRQ_EN_BIT]          = st_r.irqEn;
    end else if (regAddr == OFS_TIMER_STATUS) begin
      rdWord[STATUS_FLAG_BIT] = st_r.reachedFlag;
    end else if (regAddr == OFS_VALUE_ACK) begin
      // Captured from the pre-clear values of this very cycle
      rdWord = valueWord;
    end else if (regAddr == OFS_VALUE_PEEK) begin
      rdWord = valueWord;
    end else if (regAddr == OFS_EVENT_STATUS) begin
      rdWord[EVT_W-1:0] = st_r.evtStatus;
    end else if (regAddr == OFS_EVENT_MASK) begin
      rdWord[EVT_W-1:0] = st_r.evtMask;
    end
  end

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  logic                 runEff;
  logic                 wrapEvt;
  logic                 rollEvt;
  logic [ELAPSED_W-1:0] elapsedBase;
  logic [EVT_W-1:0]     evtSet;
  logic [EVT_W-1:0]     evtClr;

  always_comb begin
    st_nxt      = st_r;
    wrapEvt     = 1'b0;
    rollEvt     = 1'b0;
    elapsedBase = st_r.elapsed;
    evtSet      = '0;
    evtClr      = '0;

    // Enable is only sampled while the tick counter rests at zero,
    // so a disable always lets the current interval finish
    runEff = (st_r.tick == '0) ? st_r.timerEn : st_r.running;
    st_nxt.running = runEff;

    // Debug halt also blocks here, covering a pulse already in flight
    if (divTick && runEff && !coreDebugHalt) begin
      if (st_r.tick == st_r.limit) begin
        st_nxt.tick = '0;
        wrapEvt     = 1'b1;
      end else begin
        st_nxt.tick = st_r.tick + 1'b1;
      end
    end

    // Ack read clears first, then a coincident wrap counts on top
    if (rdAck) begin
      elapsedBase = '0;
    end
    if (wrapEvt) begin
      st_nxt.elapsed = elapsedBase + 1'b1;
      rollEvt        = !rdAck && (st_r.elapsed == '1);
    end else begin
      st_nxt.elapsed = elapsedBase;
    end

    // Set wins over the acknowledge
    if (wrapEvt) begin
      st_nxt.reachedFlag = 1'b1;
    end else if (rdAck) begin
      st_nxt.reachedFlag = 1'b0;
    end

    // Mode write leaves both counters untouched
    if (wrMode) begin
      st_nxt.limit   = regWrData[MODE_LIMIT_LSB +: TICK_W];
      st_nxt.timerEn = regWrData[MODE_TIMER_EN_BIT];
      st_nxt.irqEn   = regWrData[MODE_IRQ_EN_BIT];
    end

    // Sticky events, write one to clear, new events win
    evtSet[EVT_WRAP_BIT] = wrapEvt;
    evtSet[EVT_ROLL_BIT] = rollEvt;
    if (wrEvtStatus) begin
      evtClr = regWrData[EVT_W-1:0];
    end
    st_nxt.evtStatus = (st_r.evtStatus & ~evtClr) | evtSet;
    if (wrEvtMask) begin
      st_nxt.evtMask = regWrData[EVT_W-1:0];
    end

    // Read data stand for exactly one cycle after the strobe
    st_nxt.rdData = regRdStb ? rdWord : '0;

    // Registered irq is built from next state, so it changes on the same edge as its cause
    st_nxt.irqOut = (st_nxt.reachedFlag && st_nxt.irqEn)
                  || |(st_nxt.evtStatus & st_nxt.evtMask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdData = st_r.rdData;
  assign irq       = st_r.irqOut;

endmodule

// ==== tb/ptu_timer_checker.sv ====
`timescale 1ns/1ps
module ptu_timer_checker
  import ptu_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              coreDebugHalt,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic              regWrStb,
  input wire logic              regRdStb,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic              irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic enSeen_r;
  logic rdPeek;
  logic rdAck;
  assign rdPeek = regRdStb && regAddr == OFS_VALUE_PEEK;
  assign rdAck  = regRdStb && regAddr == OFS_VALUE_ACK;
  // Counters must sit at zero until software first sets the enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      enSeen_r <= 1'b0;
    else if (regWrStb && regAddr == OFS_TIMER_MODE && regWrData[MODE_TIMER_EN_BIT])
      enSeen_r <= 1'b1;
  end
  property p_rd_idle;
    !$past(regRdStb) |-> regRdData == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  property p_unmapped;
    $past(regRdStb) && $past(regAddr) > OFS_EVENT_MASK |-> regRdData == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status;
    $past(regRdStb) && $past(regAddr) == OFS_TIMER_STATUS |-> regRdData[31:1] == '0;
  endproperty
  a_status: assert property (p_status) else $error("status spare bits set");
  property p_mode;
    $past(regRdStb) && $past(regAddr) == OFS_TIMER_MODE
      |-> regRdData[31:26] == '0 && regRdData[23:20] == '0;
  endproperty
  a_mode: assert property (p_mode) else $error("mode spare bits set");
  property p_idle;
    $past(rdPeek) && !$past(enSeen_r) |-> regRdData == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("counters moved while off");
  property p_step;
    rdPeek ##1 rdPeek |=> regRdData[19:0] == $past(regRdData[19:0])
      || regRdData[19:0] == $past(regRdData[19:0]) + 20'h1 || regRdData[19:0] == '0;
  endproperty
  a_step: assert property (p_step) else $error("tick jumped");
  property p_halt;
    coreDebugHalt && rdPeek ##1 coreDebugHalt && rdPeek |=> $stable(regRdData);
  endproperty
  a_halt: assert property (p_halt) else $error("counters moved in debug");
  property p_ack_peek;
    rdAck ##1 rdPeek |=> regRdData[31:20] <= 12'h1;
  endproperty
  a_ack_peek: assert property (p_ack_peek) else $error("elapsed not cleared");
  cover property (rdPeek ##1 rdPeek);
  cover property ($rose(irq));
  cover property (rdAck && irq);
  cover property (rdAck ##1 rdPeek);
endmodule

bind ptu_timer ptu_timer_checker u_ptu_timer_checker (.core_clk, .rst_n, .coreDebugHalt,
  .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .irq);

// ==== tb/ptu_timer_tb.sv ====
`timescale 1ns/1ps
module ptu_timer_tb;
  import ptu_pkg::*;
  logic              core_clk, rst_n, coreDebugHalt, regWrStb, regRdStb, irq;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData;
  int                mismatches, num_checks, n;

  ptu_timer u_ptu_timer (.core_clk, .rst_n, .coreDebugHalt, .regAddr, .regWrData,
    .regWrStb, .regRdStb, .regRdData, .irq);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr   <= a;
    regWrData <= v;
    regWrStb  <= 1'b1;
    @(posedge core_clk);
    regWrStb <= 1'b0;
    #1;
  endtask

  // Returns one nanosecond after the edge on which irq is seen high
  task automatic wait_irq(output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      #1;
      c++;
    end while (irq !== 1'b1 && c < 3000);
    if (irq !== 1'b1)
      mismatches++;
  endtask

  initial begin
    repeat (80000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end

  initial begin
    {rst_n, coreDebugHalt, regWrStb, regRdStb} = 4'h0;
    regAddr   = 8'h00;
    regWrData = 32'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(OFS_TIMER_MODE, 32'h000f_ffff);
    rd(OFS_TIMER_STATUS, 32'h0);
    rd(OFS_VALUE_ACK, 32'h0);
    rd(OFS_VALUE_PEEK, 32'h0);
    rd(OFS_EVENT_MASK, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0);
    wr(OFS_TIMER_MODE, 32'h0300_0003);
    wait_irq(n);
    rd(OFS_VALUE_ACK, 32'h0010_0000);
    rd(OFS_TIMER_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wait_irq(n);
    // Two cycles of the period went on the ack and status reads
    chk(32'(n + 2), 32'd64);
    rd(OFS_VALUE_ACK, 32'h0010_0000);
    repeat (40) @(posedge core_clk);
    rd(OFS_VALUE_PEEK, 32'h2);
    wr(OFS_TIMER_MODE, 32'h0300_0007);
    rd(OFS_VALUE_PEEK, 32'h2);
    wait_irq(n);
    rd(OFS_VALUE_ACK, 32'h0010_0000);
    repeat (383) @(posedge core_clk);
    rd(OFS_VALUE_PEEK, 32'h0030_0000);
    rd(OFS_TIMER_STATUS, 32'h1);
    rd(OFS_VALUE_ACK, 32'h0030_0000);
    repeat (40) @(posedge core_clk);
    wr(OFS_TIMER_MODE, 32'h0000_0007);
    repeat (300) @(posedge core_clk);
    rd(OFS_VALUE_PEEK, 32'h0010_0000);
    chk({31'h0, irq}, 32'h0);
    rd(OFS_TIMER_STATUS, 32'h1);
    rd(OFS_VALUE_ACK, 32'h0010_0000);
    rd(OFS_EVENT_STATUS, 32'h1);
    wr(OFS_EVENT_MASK, 32'h1);
    repeat (2) @(posedge core_clk);
    #1;
    chk({31'h0, irq}, 32'h1);
    wr(OFS_EVENT_STATUS, 32'h1);
    repeat (2) @(posedge core_clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    rd(OFS_EVENT_STATUS, 32'h0);
    // Mask the wrap event again so irq only follows the reached flag
    wr(OFS_EVENT_MASK, 32'h0);
    wr(OFS_TIMER_MODE, 32'h0300_0003);
    wait_irq(n);
    rd(OFS_VALUE_ACK, 32'h0010_0000);
    coreDebugHalt <= 1'b1;
    rd(OFS_VALUE_PEEK, 32'h0);
    rd(OFS_VALUE_PEEK, 32'h0);
    repeat (200) @(posedge core_clk);
    rd(OFS_VALUE_PEEK, 32'h0);
    coreDebugHalt <= 1'b0;
    wait_irq(n);
    rd(OFS_VALUE_ACK, 32'h0010_0000);
    // Limit zero wraps on every divided tick; 4097 wraps roll elapsed to 1
    wr(OFS_TIMER_MODE, 32'h0100_0000);
    repeat (65557) @(posedge core_clk);
    rd(OFS_VALUE_PEEK, 32'h0010_0000);
    rd(OFS_EVENT_STATUS, 32'h3);
    repeat (6) @(posedge core_clk);
    // This ack lands on a wrap edge, so the new interval survives the clear
    rd(OFS_VALUE_ACK, 32'h0010_0000);
    rd(OFS_VALUE_PEEK, 32'h0010_0000);
    rd(OFS_TIMER_STATUS, 32'h1);
    stop_test();
  end
endmodule
